// [tb.sv]
// testbench: command port, code pins, test-port sharing and reset of the receiver
`timescale 1ns/10ps
module tb import vsr_pkg::*;;
   localparam logic [9:0] LOW  = 10'h100;
   localparam logic [9:0] HIGH = 10'h2F0;
   logic            clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ce = 1'b1;
   logic            blank = 1'b0, bad_addr = 1'b0, tdi = 1'b0, pwm_out = 1'b0, test_do = 1'b0;
   logic [7:0]      addr = 8'h00;
   logic [31:0]     wdata = 32'h0, rdata;
   logic            tdo, align_in, test_di, test_en, running;
   vsr_pins_s [1:0] pins;
   vsr_rail_s [1:0] rail;
   int              n_errors = 0, n_compared = 0;

   vsr_top vsr_top_inst (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_CE(ce), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CODE_PINS(pins),
      .I_FLASH_BLANK(blank), .I_ADDR_INVALID(bad_addr), .I_TDI_ALIGN_PIN(tdi),
      .O_TDO_ALIGN_PIN(tdo), .I_PWM_ALIGN_OUT(pwm_out), .I_TEST_DO(test_do),
      .O_PWM_ALIGN_IN(align_in), .O_TEST_DI(test_di), .O_TEST_EN(test_en),
      .O_RUNNING(running), .O_RAIL(rail));
   vsr_host vsr_host_inst (.o_pins(pins));

   // 250 MHz system clock
   always #2 clk = ~clk;

   task automatic close_out();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // a wait that ran out of its bound ends the run
   task automatic hang();
      n_errors++;
      $display("[FAIL] t=%0t wait bound used up", $time);
      close_out();
   endtask

   task automatic chk(input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // write: one cycle of strobe beside address and data
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // read: data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic wait_run();
      for (int n = 0; running !== 1'b1; n++) begin
         if (n > 60)
            hang();
         @(posedge clk);
         #1;
      end
   endtask

   // counts cycles to the rail's slew start, then checks timing and values
   task automatic wait_upd(input int r, lo, hi, input logic [9:0] sp, input logic [7:0] cd);
      int n;
      for (n = 0; rail[r].upd !== 1'b1; n++) begin
         if (n > 40000)
            hang();
         @(posedge clk);
         #1;
      end
      chk({31'h0, n >= lo && n <= hi}, 32'h1);
      chk({22'h0, rail[r].setpoint}, {22'h0, sp});
      chk({24'h0, rail[r].code}, {24'h0, cd});
   endtask

   // expected setpoint, truncated like the divider
   function automatic logic [9:0] sp_of(input int code, w);
      return 10'(int'(LOW) + code * (int'(HIGH) - int'(LOW)) / ((1 << w) - 1));
   endfunction

   function automatic logic [31:0] cfg_word(input vsr_mode_e m);
      return {2'b00, 8'h80, HIGH, LOW, m};
   endfunction

   // shared pins: test side when enabled, align side otherwise
   task automatic pin_chk(input logic en);
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         tdi     <= p[0];
         pwm_out <= p[0];
         test_do <= ~p[0];
         repeat (8) @(posedge clk);
         #1;
         chk({29'h0, tdo, align_in, test_di}, {29'h0, en ^ p[0], ~en & p[0], en & p[0]});
      end
   endtask

   initial begin
      repeat (8) @(posedge clk);
      chk({30'h0, running, test_en}, 32'h0);
      chk({13'h0, rail[0]}, 32'h0);
      rstn <= 1'b1;
      bus_wr(ADDR_CODE_SETUP, cfg_word(VSR_MODE_EIGHT));
      wait_run();
      fork
         wait_upd(0, SER_MIN_CYC, SER_MAX_CYC, sp_of(128, 8), 8'h80);
         wait_upd(1, SER_MIN_CYC, SER_MAX_CYC, sp_of(128, 8), 8'h80);
      join
      bus_rd(ADDR_STATUS, 32'h1);
      // rail one by command while rail two sees a pin frame
      bus_wr(ADDR_RAIL1_CODE, 32'hFF);
      fork
         begin
            vsr_host_inst.half(1'b0, 2'b10, 6'h00, 6'h15);
            vsr_host_inst.half(1'b1, 2'b10, 6'h00, 6'h15);
         end
         wait_upd(0, SER_MIN_CYC, SER_MAX_CYC, sp_of(255, 8), 8'hFF);
      join
      chk({14'h0, rail[1].setpoint, rail[1].code}, {14'h0, sp_of(128, 8), 8'h80});
      bus_wr(ADDR_RAIL2_CODE, 32'h40);
      wait_upd(1, SER_MIN_CYC, SER_MAX_CYC, sp_of(64, 8), 8'h40);
      chk({22'h0, rail[0].setpoint}, {22'h0, sp_of(255, 8)});
      bus_rd(ADDR_RAIL1_CODE, {14'h0, sp_of(255, 8), 8'hFF});
      bus_rd(ADDR_RAIL2_CODE, {14'h0, sp_of(64, 8), 8'h40});
      bus_rd(8'h55, 32'h0);
      bus_rd(ADDR_ROM_ENTRY, 32'h0);
      // six-bit codes on both rails, distinct and rare
      bus_wr(ADDR_CODE_SETUP, cfg_word(VSR_MODE_SIX));
      bus_rd(ADDR_CODE_SETUP, cfg_word(VSR_MODE_SIX));
      vsr_host_inst.half(1'b0, 2'b11, 6'h2D, 6'h12);
      fork
         vsr_host_inst.half(1'b1, 2'b11, 6'h2D, 6'h12);
         wait_upd(0, PAR_MIN_CYC, PAR_MAX_CYC, sp_of(45, 6), 8'h2D);
         wait_upd(1, PAR_MIN_CYC, PAR_MAX_CYC, sp_of(18, 6), 8'h12);
      join
      pin_chk(1'b0);
      bus_wr(ADDR_ROM_ENTRY, 32'h0);
      pin_chk(1'b1);
      bus_rd(ADDR_STATUS, 32'h3);
      // clock enable low must freeze the filtered pin path and its outputs
      @(posedge clk);
      ce  <= 1'b0;
      tdi <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk({31'h0, test_di}, 32'h1);
      @(posedge clk);
      ce <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      chk({31'h0, test_di}, 32'h0);
      // resets with each strap condition
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         blank    <= (k == 1);
         bad_addr <= (k == 2);
         rstn     <= 1'b0;
         repeat (3) @(posedge clk);
         chk({30'h0, running, test_en}, 32'h0);
         rstn <= 1'b1;
         // running rises on the enabled edge after the startup count is reached
         repeat (STARTUP_CYC) @(posedge clk);
         #1;
         chk({31'h0, running}, 32'h0);
         @(posedge clk);
         #1;
         chk({31'h0, running}, 32'h1);
         wait_run();
         repeat (2) @(posedge clk);
         #1;
         chk({31'h0, test_en}, {31'h0, k != 0});
      end
      close_out();
   end
endmodule // tb

// [vsr_host.sv]
// partner model: host driving the per-rail code select and data lines
`timescale 1ns/10ps
module vsr_host import vsr_pkg::*; #(
   parameter int HOLD = 875  // link periods of 80 ns in 70 us
) (
   output vsr_pins_s [1:0] o_pins  // select and data lines of both rails
);
   logic lclk;

   // host timebase, offset in phase from the system clock on purpose
   initial begin
      lclk = 1'b0;
      #13;
      forever #40 lclk = ~lclk;
   end

   // select idles high between frames, data low until the first frame, then the inverted last bits
   initial o_pins = {2{4'h8}};

   // one half of a code: select level with its three bits, then hold
   task automatic half(input logic hi, input logic [1:0] m, input logic [5:0] c0, c1);
      logic [5:0] c [2];
      c[0] = c0;
      c[1] = c1;
      @(posedge lclk);
      for (int r = 0; r < 2; r++)
         if (m[r]) o_pins[r] <= {hi, hi ? c[r][5:3] : c[r][2:0]};
      repeat (HOLD) @(posedge lclk);
      // hold over: data lines stop carrying the code, select stays put
      for (int r = 0; r < 2; r++)
         if (m[r]) o_pins[r][2:0] <= ~o_pins[r][2:0];
   endtask
endmodule // vsr_host

// [vsr_pkg.sv]
// package: constants, field layouts and carrier types of the code-select setpoint receiver
package vsr_pkg;
   // command port offsets (byte codes of the serial commands)
   localparam logic [7:0]  ADDR_STATUS     = 8'h00;
   localparam logic [7:0]  ADDR_CODE_SETUP = 8'hBB;
   localparam logic [7:0]  ADDR_RAIL1_CODE = 8'hBC;
   localparam logic [7:0]  ADDR_RAIL2_CODE = 8'hBD;
   localparam logic [7:0]  ADDR_ROM_ENTRY  = 8'hD6;
   // code setup word layout
   localparam int          F_MODE_LSB      = 0;
   localparam int          F_LOW_LSB       = 2;
   localparam int          F_HIGH_LSB      = 12;
   localparam int          F_INIT_LSB      = 22;
   // setup reset values
   localparam logic [9:0]  RST_LOW         = 10'h000;
   localparam logic [9:0]  RST_HIGH        = 10'h3FF;
   localparam logic [7:0]  RST_INIT        = 8'h00;
   // divisors 2^width - 1 for the three code widths
   localparam logic [7:0]  DEN_FOUR        = 8'h0F;
   localparam logic [7:0]  DEN_SIX         = 8'h3F;
   localparam logic [7:0]  DEN_EIGHT       = 8'hFF;
   localparam logic [4:0]  DIV_STEPS       = 5'h12;
   // timing
   localparam int          CLK_MHZ         = 250;
   localparam int          T_PAR_MIN_US    = 35;
   localparam int          T_PAR_MAX_US    = 135;
   localparam int          T_SER_MIN_US    = 28;
   localparam int          T_SER_MAX_US    = 140;
   localparam int          PAR_MIN_CYC     = T_PAR_MIN_US * CLK_MHZ;
   localparam int          PAR_MAX_CYC     = T_PAR_MAX_US * CLK_MHZ;
   localparam int          SER_MIN_CYC     = T_SER_MIN_US * CLK_MHZ;
   localparam int          SER_MAX_CYC     = T_SER_MAX_US * CLK_MHZ;
   localparam logic [7:0]  STARTUP_CYC     = 8'h10;

   typedef enum logic [1:0] {VSR_MODE_FOUR, VSR_MODE_SIX, VSR_MODE_EIGHT, VSR_MODE_RSVD} vsr_mode_e;
   localparam vsr_mode_e   RST_MODE        = VSR_MODE_SIX;

   typedef struct packed {
      logic [7:0] init_code;
      logic [9:0] high;
      logic [9:0] low;
      vsr_mode_e  mode;
   } vsr_cfg_s;

   typedef struct packed {
      logic sel;
      logic c;
      logic b;
      logic a;
   } vsr_pins_s;

   typedef struct packed {
      logic       upd;
      logic [9:0] setpoint;
      logic [7:0] code;
   } vsr_rail_s;
endpackage

// [vsr_rail.sv]
// module: one rail's code capture, setpoint arithmetic and response delay
`timescale 1ns/10ps
module vsr_rail import vsr_pkg::*; #(
   parameter int PAR_DLY = PAR_MIN_CYC,
   parameter int SER_DLY = SER_MIN_CYC
) (
   input  wire logic       i_clk,      // system clock
   input  wire logic       i_rstn,     // async reset, active low
   input  wire logic       i_ce,       // clock enable
   input  wire logic       i_run,      // normal operation
   input  wire vsr_cfg_s   i_cfg,      // code setup
   input  wire vsr_pins_s  i_pins,     // synchronised code pins
   input  wire logic       i_ser_wr,   // serial code command strobe
   input  wire logic [7:0] i_ser_code, // serial code
   input  wire logic       i_init,     // load power-up code
   output vsr_rail_s       o_rail      // setpoint, code, slew start
);
   typedef enum {ST_IDLE, ST_CALC, ST_WAIT} vsr_st_e;
   vsr_st_e     st_reg;
   logic        sel_q_reg;
   logic [2:0]  low_bits_reg;
   logic [8:0]  rem_reg;
   logic [17:0] num_reg;
   logic [7:0]  den_reg;
   logic [9:0]  low_reg;
   logic [9:0]  diff_reg;
   logic [15:0] cnt_reg;
   logic        src_par_reg;
   logic [15:0] age_reg;

   // edges on the filtered select level; data is already stable by then
   wire        fall     = sel_q_reg & ~i_pins.sel;
   wire        rise     = ~sel_q_reg & i_pins.sel;
   wire        par_on   = i_run & (i_cfg.mode == VSR_MODE_SIX);
   wire        ser_on   = i_run & (i_cfg.mode == VSR_MODE_EIGHT);
   wire        idle     = (st_reg == ST_IDLE);
   wire        par_go   = rise & par_on & idle;
   wire        ser_go   = i_ser_wr & ser_on & idle;
   wire        go       = par_go | ser_go | (i_init & idle);
   wire [7:0]  par_code = {2'b00, i_pins.c, i_pins.b, i_pins.a, low_bits_reg};
   wire [7:0]  go_code  = par_go ? par_code : (ser_go ? i_ser_code : i_cfg.init_code);
   wire [9:0]  go_diff  = (i_cfg.high > i_cfg.low) ? 10'(i_cfg.high - i_cfg.low) : 10'h000;
   wire [7:0]  go_den   = (i_cfg.mode == VSR_MODE_EIGHT) ? DEN_EIGHT :
                          (i_cfg.mode == VSR_MODE_FOUR) ? DEN_FOUR : DEN_SIX;
   wire [8:0]  trial    = {rem_reg[7:0], num_reg[17]};
   wire        ge       = trial >= {1'b0, den_reg};
   wire [15:0] dly      = src_par_reg ? 16'(PAR_DLY - 1) : 16'(SER_DLY - 1);

   // low half of a parallel code on the falling select edge
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sel_q_reg    <= 1'b0;
         low_bits_reg <= 3'h0;
      end else if (i_ce) begin
         sel_q_reg <= i_pins.sel;
         if (fall && par_on) begin
            low_bits_reg <= {i_pins.c, i_pins.b, i_pins.a};
         end
      end
   end

   // restoring divide of code*(high-low) by 2^width-1, then the response wait
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg      <= ST_IDLE;
         rem_reg     <= 9'h000;
         num_reg     <= 18'h00000;
         den_reg     <= 8'h00;
         low_reg     <= 10'h000;
         diff_reg    <= 10'h000;
         cnt_reg     <= 16'h0000;
         src_par_reg <= 1'b0;
         o_rail      <= '0;
      end else if (i_ce) begin
         o_rail.upd <= 1'b0;
         case (st_reg)
            ST_IDLE: begin
               if (go) begin
                  o_rail.code <= go_code;
                  num_reg     <= 18'(go_code * go_diff);
                  rem_reg     <= 9'h000;
                  den_reg     <= go_den;
                  low_reg     <= i_cfg.low;
                  diff_reg    <= go_diff;
                  src_par_reg <= par_go;
                  cnt_reg     <= 16'(DIV_STEPS - 5'h01);
                  st_reg      <= ST_CALC;
               end
            end
            ST_CALC: begin
               rem_reg <= ge ? 9'(trial - {1'b0, den_reg}) : trial;
               num_reg <= {num_reg[16:0], ge};
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg == 16'h0000) begin
                  cnt_reg <= dly;
                  st_reg  <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               cnt_reg <= cnt_reg - 16'h0001;
               if (cnt_reg == 16'h0000) begin
                  o_rail.setpoint <= 10'(low_reg + num_reg[9:0]);
                  o_rail.upd      <= 1'b1;
                  st_reg          <= ST_IDLE;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // helper: cycles since the code was taken, read only by the checks below
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         age_reg <= 16'h0000;
      end else if (i_ce) begin
         age_reg <= idle ? 16'h0000 : age_reg + 16'h0001;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_par_resp_window: assert property (
      (o_rail.upd && src_par_reg) |-> (age_reg >= 16'(PAR_MIN_CYC) && age_reg <= 16'(PAR_MAX_CYC)))
      else $error("parallel code response outside window");
   a_ser_resp_window: assert property (
      (o_rail.upd && !src_par_reg) |-> (age_reg >= 16'(SER_MIN_CYC) && age_reg <= 16'(SER_MAX_CYC)))
      else $error("serial code response outside window");
   a_low_capture: assert property (
      (i_ce && fall && par_on) |=> (low_bits_reg == $past({i_pins.c, i_pins.b, i_pins.a})))
      else $error("low code bits not captured on falling select");
   a_pins_ignored: assert property (
      (i_ce && idle && rise && !par_on && !i_ser_wr && !i_init) |=> (st_reg == ST_IDLE))
      else $error("pins acted outside six-bit mode");
   a_setpoint_formula: assert property (
      o_rail.upd |-> (o_rail.setpoint == 10'(low_reg + 18'(o_rail.code * diff_reg) / den_reg)))
      else $error("setpoint differs from code times slope plus low");
endmodule // vsr_rail

// [vsr_sync.sv]
// module: three-stage synchroniser with agreement filter, one per bit
`timescale 1ns/10ps
module vsr_sync import vsr_pkg::*; #(
   parameter int W = 4
) (
   input  wire logic         i_clk,    // system clock
   input  wire logic         i_rstn,   // async reset, active low
   input  wire logic         i_ce,     // clock enable
   input  wire logic [W-1:0] i_async,  // pins from outside the domain
   output logic      [W-1:0] o_level   // filtered level
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // s1 feeds only s2; a change counts once s2 and s3 agree
         always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
               s1_reg[g]  <= 1'b0;
               s2_reg[g]  <= 1'b0;
               s3_reg[g]  <= 1'b0;
               o_level[g] <= 1'b0;
            end else if (i_ce) begin
               s1_reg[g] <= i_async[g];
               s2_reg[g] <= s1_reg[g];
               s3_reg[g] <= s2_reg[g];
               if (s2_reg[g] == s3_reg[g]) begin
                  o_level[g] <= s3_reg[g];
               end
            end
         end

         a_level_agree: assert property (@(posedge i_clk) disable iff (!i_rstn)
            (o_level[g] != $past(o_level[g])) |-> ($past(s2_reg[g]) == $past(s3_reg[g])))
            else $error("filtered level changed without agreement");
      end
   endgenerate
endmodule // vsr_sync

// [vsr_top.sv]
// module: top of the code-select setpoint receiver with command port and test-port pin sharing
//
// Operation
// - slew starts 35 to 135 us after rise
// - eight-bit mode ignores pins, takes command codes
// - command 0xBB sets mode, limits, power-up code
// - commands 0xBC/0xBD carry rail one/two codes
// - serial code applied 28 to 140 us later
// - message start to slew typically 169-314 us
// - test port off at reset, on by rom-entry
// - blank config flash enables test port
// - invalid bus address enables test port
// - enabled test port takes over align pins
// - startup sequence then normal operation
// - held in reset while reset low
// - falling select captures bits 2:0
// - rising select captures bits 5:3, computes
// - reference equals code times slope plus low
`timescale 1ns/10ps
module vsr_top import vsr_pkg::*; #(
   parameter int PAR_DLY = PAR_MIN_CYC,  // cycles from select rise to slew start
   parameter int SER_DLY = SER_MIN_CYC   // cycles from serial code to slew start
) (
   input  wire logic            I_SYS_CLK,        // 250 MHz system clock
   input  wire logic            I_RESETN,         // external reset, active low
   input  wire logic            I_CE,             // clock enable
   input  wire logic [7:0]      I_ADDR,           // command port address
   input  wire logic [31:0]     I_WDATA,          // command port write data
   input  wire logic            I_WR,             // write strobe
   input  wire logic            I_RD,             // read strobe
   output logic      [31:0]     O_RDATA,          // read data, cycle after strobe
   input  wire vsr_pins_s [1:0] I_CODE_PINS,      // per-rail select and data lines
   input  wire logic            I_FLASH_BLANK,    // config flash blank strap
   input  wire logic            I_ADDR_INVALID,   // address pins decode invalid
   input  wire logic            I_TDI_ALIGN_PIN,  // shared test-in / align-in pin
   output logic                 O_TDO_ALIGN_PIN,  // shared test-out / align-out pin
   input  wire logic            I_PWM_ALIGN_OUT,  // align output from pwm logic
   input  wire logic            I_TEST_DO,        // test data out from test logic
   output logic                 O_PWM_ALIGN_IN,   // align input to pwm logic
   output logic                 O_TEST_DI,        // test data in to test logic
   output logic                 O_TEST_EN,        // test port enabled
   output logic                 O_RUNNING,        // startup done
   output vsr_rail_s [1:0]      O_RAIL            // per-rail code, setpoint, slew start
);
   vsr_cfg_s    cfg_reg;
   logic        test_en_reg;
   logic        running_reg;
   logic [7:0]  start_cnt_reg;
   logic        init_reg;
   logic [31:0] rdata_next;
   logic [5:0]  strap_lvl;
   logic [7:0]  pin_lvl;

   // command decode
   wire       wr_setup = I_WR & (I_ADDR == ADDR_CODE_SETUP);
   wire       wr_rom   = I_WR & (I_ADDR == ADDR_ROM_ENTRY);
   wire [1:0] rail_wr  = {I_WR & (I_ADDR == ADDR_RAIL2_CODE),
                          I_WR & (I_ADDR == ADDR_RAIL1_CODE)};
   wire       start_end = !running_reg && (start_cnt_reg == STARTUP_CYC);
   wire       tdi_lvl   = strap_lvl[2];

   // straps and shared input pin cross from outside the clock domain
   vsr_sync #(.W(6)) u_strap_sync (
      .i_clk   (I_SYS_CLK),
      .i_rstn  (I_RESETN),
      .i_ce    (I_CE),
      .i_async ({3'b000, I_TDI_ALIGN_PIN, I_ADDR_INVALID, I_FLASH_BLANK}),
      .o_level (strap_lvl)
   );

   // code pins of both rails, one synchroniser bank
   vsr_sync #(.W(8)) u_pin_sync (
      .i_clk   (I_SYS_CLK),
      .i_rstn  (I_RESETN),
      .i_ce    (I_CE),
      .i_async (I_CODE_PINS),
      .o_level (pin_lvl)
   );

   genvar r;
   generate
      for (r = 0; r < 2; r++) begin : g_rail
         // independent state per rail so one rail's codes never reach the other
         vsr_rail #(.PAR_DLY(PAR_DLY), .SER_DLY(SER_DLY)) u_rail (
            .i_clk      (I_SYS_CLK),
            .i_rstn     (I_RESETN),
            .i_ce       (I_CE),
            .i_run      (running_reg),
            .i_cfg      (cfg_reg),
            .i_pins     (vsr_pins_s'(pin_lvl[4*r +: 4])),
            .i_ser_wr   (rail_wr[r]),
            .i_ser_code (I_WDATA[7:0]),
            .i_init     (init_reg),
            .o_rail     (O_RAIL[r])
         );
      end
   endgenerate

   // startup sequence: reset release counts up to STARTUP_CYC, then straps are sampled
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         start_cnt_reg <= 8'h00;
         running_reg   <= 1'b0;
         init_reg      <= 1'b0;
      end else if (I_CE) begin
         init_reg <= start_end;
         if (!running_reg) begin
            start_cnt_reg <= start_cnt_reg + 8'h01;
         end
         if (start_end) begin
            running_reg <= 1'b1;
         end
      end
   end

   // code setup word; limits and mode take effect on the next code
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         cfg_reg <= '{init_code: RST_INIT, high: RST_HIGH, low: RST_LOW, mode: RST_MODE};
      end else if (I_CE && wr_setup) begin
         cfg_reg.mode      <= vsr_mode_e'(I_WDATA[F_MODE_LSB +: 2]);
         cfg_reg.low       <= I_WDATA[F_LOW_LSB +: 10];
         cfg_reg.high      <= I_WDATA[F_HIGH_LSB +: 10];
         cfg_reg.init_code <= I_WDATA[F_INIT_LSB +: 8];
      end
   end

   // test port: off at reset; straps can only turn it on, never off
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         test_en_reg <= 1'b0;
      end else if (I_CE) begin
         if (wr_rom) begin
            test_en_reg <= 1'b1;
         end
         if (start_end && (strap_lvl[0] || strap_lvl[1])) begin
            test_en_reg <= 1'b1;
         end
      end
   end

   // shared pins: the align path is dead while the test port owns them
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_TDO_ALIGN_PIN <= 1'b0;
         O_PWM_ALIGN_IN  <= 1'b0;
         O_TEST_DI       <= 1'b0;
      end else if (I_CE) begin
         O_TDO_ALIGN_PIN <= test_en_reg ? I_TEST_DO : I_PWM_ALIGN_OUT;
         O_PWM_ALIGN_IN  <= ~test_en_reg & tdi_lvl;
         O_TEST_DI       <= test_en_reg & tdi_lvl;
      end
   end

   // read mux; unmapped and write-only offsets read zero
   always_comb begin
      rdata_next = 32'h00000000;
      case (I_ADDR)
         ADDR_STATUS:     rdata_next = {30'h00000000, test_en_reg, running_reg};
         ADDR_CODE_SETUP: rdata_next = {2'b00, cfg_reg};
         ADDR_RAIL1_CODE: rdata_next = {14'h0000, O_RAIL[0].setpoint, O_RAIL[0].code};
         ADDR_RAIL2_CODE: rdata_next = {14'h0000, O_RAIL[1].setpoint, O_RAIL[1].code};
         default:         rdata_next = 32'h00000000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_RDATA <= 32'h00000000;
      end else if (I_CE) begin
         O_RDATA <= I_RD ? rdata_next : 32'h00000000;
      end
   end

   assign O_TEST_EN = test_en_reg;
   assign O_RUNNING = running_reg;

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESETN);

   a_rom_enables_test: assert property (
      (I_CE && wr_rom) |=> O_TEST_EN)
      else $error("rom entry did not enable test port");
   a_test_owns_tdo: assert property (
      (I_CE && test_en_reg) |=> (O_TDO_ALIGN_PIN == $past(I_TEST_DO) && !O_PWM_ALIGN_IN))
      else $error("align path active while test port enabled");
   a_strap_enables_test: assert property (
      (I_CE && start_end && (strap_lvl[0] || strap_lvl[1])) |=> O_TEST_EN)
      else $error("strap did not enable test port");
   a_setup_write: assert property (
      (I_CE && wr_setup) |=> (cfg_reg.low == $past(I_WDATA[11:2])
                              && cfg_reg.init_code == $past(I_WDATA[29:22])))
      else $error("setup command not stored");
   a_rail_select: assert property (
      (I_CE && rail_wr[0] && !init_reg && cfg_reg.mode == VSR_MODE_EIGHT)
      |=> $stable(O_RAIL[1].code))
      else $error("rail one command altered rail two");
   a_startup_time: assert property (
      (I_CE && start_end) |=> (O_RUNNING && $past(start_cnt_reg) == STARTUP_CYC))
      else $error("startup length wrong");
endmodule // vsr_top
